// ==== pkg/dscc_regs.vh ====
// Constants of the dual source clock control block
`ifndef DSCC_REGS_VH
`define DSCC_REGS_VH
`define DSCC_PRESET_VAL    13'h0078
`define DSCC_PRE_W         7
`define DSCC_POR_W         6
`define DSCC_SEL_DIV2      2'h0
`define DSCC_SEL_DIV4      2'h1
`define DSCC_SEL_DIV64     2'h2
`define DSCC_SEL_SUB       2'h3
`define DSCC_SEL_RESET     2'h2
`define DSCC_TAP_DIV2      0
`define DSCC_TAP_DIV4      1
`define DSCC_TAP_DIV64     5
`define DSCC_TAP_DIV128    6
`define DSCC_OPT_W         4
`endif

// ==== core/dscc_sync.v ====
// Three stage synchroniser with agreement filter
`timescale 1ns/1ps
module dscc_sync (
  clk,
  srst,
  din,
  dout
);
  input  wire clk;
  input  wire srst;
  input  wire din;
  output reg  dout;

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // dscc_sync

// ==== core/dscc_top.v ====
// Dual source clock control: prescaler, stabilisation counter, clock select
// Operation
// - Seven-bit prescaler on main source; taps /2, /4, /64, /128.
// - Six-bit stabilisation counter on /128; overflow sets stable flag, releases hold.
// - Power-on or enable clear presets prescaler and counter to 0x0078.
// - Selected system clock feeds all modules except timebase.
// - Select 00=/2, 01=/4, 10=/64 main, 11=sub /2.
// - Reset selects main source divided by 64.
// - Sub source runs always; nothing halts it, not even stop.
// - Stop or cleared enable halts the main source.
// - Stop on main clock halts source, clears counter, keeps prescaler.
// - Stop exit restarts main source if enabled; after stop on main clock, holds reset until overflow.
// - External reset restores select to /64 and sets enable.
// - Sub stable status bit shows sub clock available.
// - Mask options of both sources readable as read-only status.
// - Entering stop clears main stable flag and initialises counter.
// - Re-enabling main source restarts it; flag after 8072 counts.
`timescale 1ns/1ps
`include "dscc_regs.vh"
module dscc_top #(
  parameter OPT_W = `DSCC_OPT_W
) (
  clk,
  srst,
  por_detect,
  ext_reset,
  main_tick,
  sub_tick,
  sub_stable_in,
  stop_req,
  stop_exit,
  sysclk_select_high,
  sysclk_select_low,
  sel_wr,
  main_source_enable_wr,
  main_source_enable_in,
  mask_option_pins,
  main_source_run,
  sub_source_run,
  sysclk,
  timebase_tick,
  internal_reset,
  low_power,
  main_source_enable,
  main_source_stable_flag,
  sub_source_stable_flag,
  sysclk_sel_state,
  mask_option_readback
);
  input  wire             clk;
  input  wire             srst;
  input  wire             por_detect;
  input  wire             ext_reset;
  input  wire             main_tick;
  input  wire             sub_tick;
  input  wire             sub_stable_in;
  input  wire             stop_req;
  input  wire             stop_exit;
  input  wire             sysclk_select_high;
  input  wire             sysclk_select_low;
  input  wire             sel_wr;
  input  wire             main_source_enable_wr;
  input  wire             main_source_enable_in;
  input  wire [OPT_W-1:0] mask_option_pins;
  output reg              main_source_run;
  output reg              sub_source_run;
  output reg              sysclk;
  output reg              timebase_tick;
  output reg              internal_reset;
  output reg              low_power;
  output reg              main_source_enable;
  output reg              main_source_stable_flag;
  output reg              sub_source_stable_flag;
  output reg  [1:0]       sysclk_sel_state;
  output reg  [OPT_W-1:0] mask_option_readback;

  // ------------------------------------------------------------
  // Input synchronisers for the oscillator ticks
  // ------------------------------------------------------------
  wire main_lvl;
  wire sub_lvl;
  reg  main_prev_q;
  reg  sub_prev_q;

  dscc_sync u_main_sync (
    .clk  (clk),
    .srst (srst),
    .din  (main_tick),
    .dout (main_lvl)
  );

  dscc_sync u_sub_sync (
    .clk  (clk),
    .srst (srst),
    .din  (sub_tick),
    .dout (sub_lvl)
  );

  wire main_edge = main_lvl & ~main_prev_q & main_source_run;
  wire sub_edge  = sub_lvl & ~sub_prev_q;

  // ------------------------------------------------------------
  // Prescaler and stabilisation counter
  // ------------------------------------------------------------
  reg  [`DSCC_PRE_W-1:0] pre_q;
  reg  [`DSCC_POR_W-1:0] por_q;
  reg                    div_q;
  reg  [1:0]             sel_q;
  reg  [1:0]             sel_pend_q;
  reg                    sub_div_q;
  reg                    stop_q;

  wire [`DSCC_PRE_W-1:0] pre_nx  = pre_q + 1'b1;
  wire                   tap128  = main_edge & (&pre_q);
  wire                   por_ovf = tap128 & (&por_q);
  wire                   preset  = por_detect |
                                   (main_source_enable_wr & ~main_source_enable_in &
                                    ~ext_reset);

  // Preset word split into prescaler and stabilisation counter parts
  localparam [`DSCC_PRE_W+`DSCC_POR_W-1:0] PRESET_ALL = `DSCC_PRESET_VAL;
  localparam [`DSCC_PRE_W-1:0] PRESET_PRE = PRESET_ALL[`DSCC_PRE_W-1:0];
  localparam [`DSCC_POR_W-1:0] PRESET_POR =
    PRESET_ALL[`DSCC_PRE_W+`DSCC_POR_W-1:`DSCC_PRE_W];

  // Whether the selected divider tap toggles on a main edge
  function tap_toggle;
    input [1:0]             s;
    input [`DSCC_PRE_W-1:0] p;
    begin
      case (s)
        `DSCC_SEL_DIV2:  tap_toggle = 1'b1;
        `DSCC_SEL_DIV4:  tap_toggle = &p[`DSCC_TAP_DIV2:0];
        `DSCC_SEL_DIV64: tap_toggle = &p[`DSCC_TAP_DIV64-1:0];
        default:         tap_toggle = 1'b0;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (srst) begin
      main_prev_q             <= 1'b0;
      sub_prev_q              <= 1'b0;
      pre_q                   <= PRESET_PRE;
      por_q                   <= PRESET_POR;
      main_source_stable_flag <= 1'b0;
      internal_reset          <= 1'b1;
      main_source_run         <= 1'b1;
      sub_source_run          <= 1'b1;
      main_source_enable      <= 1'b1;
      low_power               <= 1'b0;
      stop_q                  <= 1'b0;
      sel_q                   <= `DSCC_SEL_RESET;
      sel_pend_q              <= `DSCC_SEL_RESET;
      div_q                   <= 1'b0;
      sub_div_q               <= 1'b0;
      sysclk                  <= 1'b0;
      timebase_tick           <= 1'b0;
      sub_source_stable_flag  <= 1'b0;
      sysclk_sel_state        <= `DSCC_SEL_RESET;
      mask_option_readback    <= {OPT_W{1'b0}};
    end else begin
      main_prev_q          <= main_lvl;
      sub_prev_q           <= sub_lvl;
      sub_source_run       <= 1'b1;
      mask_option_readback <= mask_option_pins;
      if (sub_stable_in) begin
        sub_source_stable_flag <= 1'b1;
      end
      timebase_tick <= tap128;
      // Enable bit; external reset restores defaults
      if (ext_reset) begin
        main_source_enable <= 1'b1;
        sel_pend_q         <= `DSCC_SEL_RESET;
      end else begin
        if (main_source_enable_wr) begin
          main_source_enable <= main_source_enable_in;
        end
        if (sel_wr) begin
          sel_pend_q <= {sysclk_select_high, sysclk_select_low};
        end
      end
      // Counters
      if (preset) begin
        pre_q                   <= PRESET_PRE;
        por_q                   <= PRESET_POR;
        main_source_stable_flag <= 1'b0;
      end else if (stop_req & ~stop_q) begin
        por_q                   <= {`DSCC_POR_W{1'b0}};
        main_source_stable_flag <= 1'b0;
      end else if (main_edge) begin
        pre_q <= pre_nx;
        if (tap128) begin
          por_q <= por_q + 1'b1;
        end
        if (por_ovf) begin
          main_source_stable_flag <= 1'b1;
        end
      end
      // Main source run and stop sequencing
      if (stop_req & ~stop_q) begin
        stop_q          <= 1'b1;
        low_power       <= 1'b1;
        main_source_run <= 1'b0;
        internal_reset  <= (sel_q != `DSCC_SEL_SUB);
      end else if (stop_q & (stop_exit | ext_reset)) begin
        stop_q          <= 1'b0;
        low_power       <= 1'b0;
        main_source_run <= main_source_enable | ext_reset;
      end else if (preset) begin
        main_source_run <= 1'b0;
      end else if (~stop_q & ext_reset) begin
        main_source_run <= 1'b1;
      end else if (~stop_q & main_source_enable_wr & main_source_enable_in) begin
        main_source_run <= 1'b1;
      end
      if (por_ovf & ~stop_q) begin
        internal_reset <= 1'b0;
      end else if (ext_reset & ~main_source_run) begin
        // Main source not yet running: hold until fresh overflow
        internal_reset <= 1'b1;
      end
      // Glitch-free system clock: switch only while output low
      if (sub_edge) begin
        sub_div_q <= ~sub_div_q;
      end
      if (main_edge & tap_toggle(sel_q, pre_q)) begin
        div_q <= ~div_q;
      end
      if (~sysclk & (sel_pend_q != sel_q)) begin
        sel_q <= sel_pend_q;
        div_q <= 1'b0;
      end
      if (sel_q == `DSCC_SEL_SUB) begin
        sysclk <= sub_div_q & ~low_power;
      end else begin
        sysclk <= div_q & ~low_power;
      end
      sysclk_sel_state <= sel_q;
    end
  end
endmodule // dscc_top

// ==== verification/dscc_checker.sv ====
// Port assertions for the dual source clock control block
`timescale 1ns/1ps
module dscc_checker #(
  parameter OPT_W = 4
) (
  input wire             clk,
  input wire             srst,
  input wire             por_detect,
  input wire             ext_reset,
  input wire             stop_req,
  input wire             main_source_enable_wr,
  input wire             main_source_enable_in,
  input wire             sel_wr,
  input wire [OPT_W-1:0] mask_option_pins,
  input wire             main_source_run,
  input wire             sub_source_run,
  input wire             internal_reset,
  input wire             low_power,
  input wire             main_source_enable,
  input wire             main_source_stable_flag,
  input wire             sub_source_stable_flag,
  input wire [1:0]       sysclk_sel_state,
  input wire [OPT_W-1:0] mask_option_readback
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sel_reset_a: assert property (disable iff (1'b0) srst |=> sysclk_sel_state == 2'h2
    && main_source_enable && internal_reset && !main_source_stable_flag) else $error("reset state");
  ext_rst_a: assert property (ext_reset && !sel_wr |=> main_source_enable
    ##[1:300] sysclk_sel_state == 2'h2) else $error("external reset defaults lost");
  sub_run_a: assert property (sub_source_run) else $error("sub source halted");
  en_clear_a: assert property (main_source_enable_wr && !main_source_enable_in && !ext_reset
    |=> !main_source_enable && !main_source_run) else $error("main source not stopped");
  stop_a: assert property (stop_req && !ext_reset && !por_detect |=> low_power
    && !main_source_run && !main_source_stable_flag) else $error("stop entry wrong");
  rst_hold_a: assert property ($fell(internal_reset) |-> ##[0:1] main_source_stable_flag)
    else $error("reset released before overflow");
  sub_keep_a: assert property (sub_source_stable_flag && !por_detect |=> sub_source_stable_flag)
    else $error("sub stable flag cleared");
  mask_rd_a: assert property ($stable(mask_option_pins) [*4]
    |-> mask_option_readback == mask_option_pins) else $error("option readback wrong");
  cover property (sel_wr);
  cover property (stop_req);
  cover property ($rose(main_source_stable_flag));
  cover property (ext_reset);
endmodule // dscc_checker

bind dscc_top dscc_checker #(.OPT_W(OPT_W)) u_chk (.clk, .srst, .por_detect, .ext_reset,
  .stop_req, .main_source_enable_wr, .main_source_enable_in, .sel_wr, .mask_option_pins,
  .main_source_run, .sub_source_run, .internal_reset, .low_power, .main_source_enable,
  .main_source_stable_flag, .sub_source_stable_flag, .sysclk_sel_state, .mask_option_readback);

// ==== verification/dscc_top_test.sv ====
// Self-checking testbench for the dual source clock control block
`timescale 1ns/1ps
module dscc_top_test;
  reg         clk = 1'b0, srst = 1'b1, por_detect = 1'b0, ext_reset = 1'b0;
  reg         main_tick = 1'b0, sub_tick = 1'b0, sub_stable_in = 1'b0, stop_req = 1'b0;
  reg         stop_exit = 1'b0, sel_wr = 1'b0, sysclk_select_high = 1'b0;
  reg         sysclk_select_low = 1'b0, main_source_enable_wr = 1'b0;
  reg         main_source_enable_in = 1'b0, osc_on = 1'b0;
  reg  [3:0]  mask_option_pins = 4'h9;
  reg  [1:0]  div_q = 2'h0;
  wire        main_source_run, sub_source_run, sysclk, internal_reset, low_power, timebase_tick;
  reg  [15:0] ph;
  wire        main_source_enable, main_source_stable_flag, sub_source_stable_flag;
  wire [1:0]  sysclk_sel_state;
  wire [3:0]  mask_option_readback;
  integer     n_fail = 0, n_compared = 0, n_ticks = 0, cyc = 0, i, k, n;
  dscc_top #(.OPT_W(4)) dut (.clk, .srst, .por_detect, .ext_reset, .main_tick, .sub_tick,
    .sub_stable_in, .stop_req, .stop_exit, .sysclk_select_high, .sysclk_select_low, .sel_wr,
    .main_source_enable_wr, .main_source_enable_in, .mask_option_pins, .main_source_run,
    .sub_source_run, .sysclk, .timebase_tick, .internal_reset, .low_power,
    .main_source_enable, .main_source_stable_flag, .sub_source_stable_flag,
    .sysclk_sel_state, .mask_option_readback);
  initial forever #5 clk = ~clk;
  // ---------------------------------------------------------------
  // Oscillator pins and run limit
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    cyc = cyc + 1;
    if (div_q == 2'h3) sub_tick <= ~sub_tick;
    if (div_q[0] && osc_on) begin
      main_tick <= ~main_tick;
      if (!main_tick) n_ticks = n_ticks + 1;
    end
    if (cyc == 80000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  task cmp(input [127:0] what, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task pulse(input integer which, input [1:0] v);
    begin
      @(posedge clk);
      {sysclk_select_high, sysclk_select_low} <= v;
      main_source_enable_in <= v[0];
      sel_wr <= (which == 0);
      main_source_enable_wr <= (which == 1);
      stop_req <= (which == 2);
      ext_reset <= (which == 3);
      stop_exit <= (which == 4);
      @(posedge clk);
      {sel_wr, main_source_enable_wr, stop_req, ext_reset, stop_exit} <= 5'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    begin
      repeat (5) @(posedge clk);
      cmp("select", 16'h2, {14'h0, sysclk_sel_state});
      cmp("enable", 16'h1, {15'h0, main_source_enable});
      cmp("sub run", 16'h1, {15'h0, sub_source_run});
      cmp("hold", 16'h1, {15'h0, internal_reset});
      cmp("options", 16'h9, {12'h0, mask_option_readback});
    end
  endtask
  task t_stable;
    begin
      osc_on <= 1'b1;
      sub_stable_in <= 1'b1;
      for (k = 0; k < 40000 && main_source_stable_flag !== 1'b1; k = k + 1) @(posedge clk);
      cmp("count ok", 16'h1, {15'h0, n_ticks >= 8064 && n_ticks <= 8200});
      repeat (3) @(posedge clk);
      cmp("hold", 16'h0, {15'h0, internal_reset});
      cmp("sub flag", 16'h1, {15'h0, sub_source_stable_flag});
    end
  endtask
  // Timebase pulse every 128 main ticks of 4 cycles each
  task t_timebase;
    begin
      for (k = 0; k < 600 && timebase_tick !== 1'b1; k = k + 1) @(posedge clk);
      @(posedge clk);
      for (n = 1; n < 600 && timebase_tick !== 1'b1; n = n + 1) @(posedge clk);
      cmp("tick gap", 16'h200, n[15:0]);
    end
  endtask
  // Restart after stop exit by external reset; slack for pin latency
  task t_recover;
    begin
      n_ticks = 0;
      for (k = 0; k < 40000 && main_source_stable_flag !== 1'b1; k = k + 1) @(posedge clk);
      cmp("restart ok", 16'h1, {15'h0, n_ticks >= 8060 && n_ticks <= 8200});
      repeat (3) @(posedge clk);
      cmp("hold", 16'h0, {15'h0, internal_reset});
    end
  endtask
  task t_select;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        pulse(0, i[1:0]);
        for (k = 0; k < 300 && sysclk_sel_state !== i[1:0]; k = k + 1) @(posedge clk);
        cmp("select", i[15:0], {14'h0, sysclk_sel_state});
        // High phase: half the ratio in source periods of 4 or 8 cycles
        ph = (i == 3) ? 16'h8 : (i == 2) ? 16'h80 : (i == 1) ? 16'h8 : 16'h4;
        for (k = 0; k < 300 && sysclk !== 1'b0; k = k + 1) @(posedge clk);
        for (k = 0; k < 300 && sysclk !== 1'b1; k = k + 1) @(posedge clk);
        for (n = 0; n < 300 && sysclk === 1'b1; n = n + 1) @(posedge clk);
        cmp("high phase", ph, n[15:0]);
      end
    end
  endtask
  task t_enable_stop;
    begin
      pulse(1, 2'h0);
      cmp("run", 16'h0, {15'h0, main_source_run});
      pulse(1, 2'h1);
      cmp("run", 16'h1, {15'h0, main_source_run});
      pulse(2, 2'h0);
      cmp("stop", 16'h2, {14'h0, low_power, main_source_run});
      pulse(4, 2'h0);
      cmp("exit", 16'h2, {13'h0, low_power, main_source_run, internal_reset});
      pulse(2, 2'h0);
      pulse(3, 2'h0);
      cmp("defaults", 16'h5, {13'h0, sysclk_sel_state, main_source_enable});
      cmp("run", 16'h1, {15'h0, main_source_run});
      cmp("hold", 16'h1, {15'h0, internal_reset});
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_stable;
    t_timebase;
    t_select;
    t_enable_stop;
    t_recover;
    complete_run;
  end
endmodule // dscc_top_test
